//--- pmsa_defines.svh
// Constants of the transceiver management and status block.
// Assumes inclusion by bare name from the clock divider, frame engine and top files of the block.
// What this block and the software driving it do
// RULE1: Index register keeps a five-bit register number; bits 7 to 5 read zero.
// RULE2: Write-data register is sixteen bits, low byte at the lower address.
// RULE3: Read-data register holds the fetched value, low byte at the lower address.
// RULE4: Writing command one starts a write, command two starts a read.
// RULE5: Management clock divides by 32, 64 or 128 per divider code.
// RULE6: Software keeps the management clock at or below its ceiling.
// RULE7: Status zero shows link up in bit 0, cable absent in bit 7.
// RULE8: Status zero bit 5 mirrors mode control bit 2, auto-negotiation off.
// RULE9: Status zero bit 4 mirrors mode control bit 1, configured speed.
// RULE10: Status zero bit 3 mirrors mode control bit 0, configured duplex.
// RULE11: Status zero bit 2 shows negotiated duplex while link is up.
// RULE12: Status zero bit 1 shows negotiated speed while link is up.
// RULE13: Status one shows activity, low-power idle and calibration; bits 6-3 zero.
// RULE14: Status one bit 2 shows a newly received auto-negotiation page.
// RULE15: Status one reads activity and calibration set after reset.
// RULE16: Activity bit sets once the transceiver reset has completed.
// RULE17: Command register clears itself when the transfer ends, read data valid.
// RULE18: Software waits for a zero command before changing index, data or command.
`ifndef PMSA_DEFINES_SVH
`define PMSA_DEFINES_SVH
`define PMSA_OFS_STAT0 8'h3c
`define PMSA_OFS_STAT1 8'h3d
`define PMSA_OFS_INDEX 8'h3f
`define PMSA_OFS_WDATA_LO 8'h40
`define PMSA_OFS_WDATA_HI 8'h41
`define PMSA_OFS_RDATA_LO 8'h42
`define PMSA_OFS_RDATA_HI 8'h43
`define PMSA_OFS_CMD 8'h44
`define PMSA_OFS_DIV 8'h45
`define PMSA_CMD_IDLE 8'h00
`define PMSA_CMD_WRITE 8'h01
`define PMSA_CMD_READ 8'h02
`define PMSA_DIV_RESET 8'h01
`define PMSA_DIV_CODE_32 8'h00
`define PMSA_DIV_CODE_64 8'h01
`define PMSA_HALF_32 7'h0f
`define PMSA_HALF_64 7'h1f
`define PMSA_HALF_128 7'h3f
`define PMSA_STAT0_RESET 8'h00
`define PMSA_STAT1_RESET 8'h81
`define PMSA_XSTAT_RESET 8'h09
`define PMSA_PHY_ADDR 5'h00
`define PMSA_PREAMBLE 32'hffffffff
`define PMSA_SOF 2'h1
`define PMSA_OP_WRITE 2'h1
`define PMSA_OP_READ 2'h2
`define PMSA_TA_WRITE 2'h2
`define PMSA_BIT_LAST 6'h3f
`define PMSA_BIT_RELEASE 6'h2e
`define PMSA_BIT_DATA 6'h30
`endif

//--- pmsa_pkg.sv
// Types shared by the management and status block.
// Assumes pmsa_defines.svh is on the include path.
package pmsa_pkg;
  typedef struct packed {
    logic link_up;
    logic cable_absent;
    logic negotiated_duplex;
    logic negotiated_speed;
    logic activity;
    logic new_page_received;
    logic low_power_idle_enable;
    logic calibration_removed;
  } pmsa_xstat_t;
  typedef struct packed {
    logic cable_absent;
    logic rsvd;
    logic auto_off;
    logic configured_speed;
    logic configured_duplex;
    logic negotiated_duplex;
    logic negotiated_speed;
    logic link_up;
  } pmsa_stat0_t;
  typedef struct packed {
    logic activity;
    logic [3:0] rsvd;
    logic new_page_received;
    logic low_power_idle_enable;
    logic calibration_removed;
  } pmsa_stat1_t;
  typedef struct packed {
    logic start;
    logic is_read;
    logic [4:0] reg_index;
    logic [15:0] wdata;
  } pmsa_req_t;
  typedef struct packed {
    logic done;
    logic [15:0] rdata;
  } pmsa_rsp_t;
  typedef enum logic [1:0] {
    PMSA_IDLE = 2'h0,
    PMSA_SHIFT = 2'h1,
    PMSA_DONE = 2'h3
  } pmsa_state_t;
endpackage : pmsa_pkg

//--- pmsa_clk_div.sv
// Management clock divider with one-cycle edge ticks.
// Assumes the divider code comes from a register on the same clock.
`timescale 1ns/100ps
`include "pmsa_defines.svh"
module pmsa_clk_div import pmsa_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] div_code_i,
  output logic mdc_o,
  output logic rise_o,
  output logic fall_o
);
  logic [6:0] cnt;
  logic [6:0] limit;
  logic [6:0] next_cnt;
  logic next_mdc;
  logic next_rise;
  logic next_fall;
  logic [7:0] gap;
  logic steady;
  always_comb begin
    limit = (div_code_i == `PMSA_DIV_CODE_32) ? `PMSA_HALF_32 :
            (div_code_i == `PMSA_DIV_CODE_64) ? `PMSA_HALF_64 : `PMSA_HALF_128; // see RULE5
    next_cnt = cnt + 7'h01;
    next_mdc = mdc_o;
    next_rise = 1'b0;
    next_fall = 1'b0;
    // Compare with >= so a smaller code taken mid-count cannot run away
    if (cnt >= limit) begin
      next_cnt = 7'h00;
      next_mdc = ~mdc_o;
      next_rise = ~mdc_o;
      next_fall = mdc_o;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 7'h00;
      mdc_o <= 1'b0;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end else begin
      cnt <= next_cnt;
      mdc_o <= next_mdc;
      rise_o <= next_rise;
      fall_o <= next_fall;
    end
  end
  // Cycles since the last toggle, with a flag that the code held meanwhile
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gap <= 8'h00;
      steady <= 1'b0;
    end else begin
      gap <= (rise_o | fall_o) ? 8'h01 : gap + 8'h01;
      steady <= (rise_o | fall_o) ? 1'b1 : steady & (div_code_i == $past(div_code_i));
    end
  end
  a_mdc_half_period: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see RULE5
    (rise_o | fall_o) && steady && $stable(div_code_i) |-> gap == {1'b0, limit} + 8'h01)
    else $error("management clock half period wrong");
endmodule : pmsa_clk_div

//--- pmsa_mgmt_engine.sv
// Serial management frame engine: 64-bit write or read frame.
// Assumes edge ticks from pmsa_clk_div and an already synchronised data input.
`timescale 1ns/100ps
`include "pmsa_defines.svh"
module pmsa_mgmt_engine import pmsa_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire pmsa_req_t req_i,
  input wire logic rise_i,
  input wire logic fall_i,
  input wire logic mdio_i,
  output pmsa_rsp_t rsp_o,
  output logic mdio_o,
  output logic mdio_oe_o
);
  pmsa_state_t state, next_state;
  logic [5:0] cnt, next_cnt;
  logic [63:0] shreg, next_shreg, frame;
  logic [15:0] rdsh, next_rdsh;
  logic rd, next_rd, next_out, next_oe, done, next_done;
  always_comb begin
    frame = {`PMSA_PREAMBLE, `PMSA_SOF, req_i.is_read ? `PMSA_OP_READ : `PMSA_OP_WRITE,
             `PMSA_PHY_ADDR, req_i.reg_index, `PMSA_TA_WRITE, req_i.wdata}; // see RULE4
    next_state = state;
    next_cnt = cnt;
    next_shreg = shreg;
    next_rdsh = rdsh;
    next_rd = rd;
    next_out = mdio_o;
    next_oe = mdio_oe_o;
    next_done = 1'b0;
    unique case (state)
      PMSA_IDLE: begin
        // Frames start on a falling edge so bit 0 is set up before the first rise
        if (req_i.start && fall_i) begin
          next_out = frame[63];
          next_shreg = {frame[62:0], 1'b0};
          next_oe = 1'b1;
          next_rd = req_i.is_read;
          next_cnt = 6'h00;
          next_state = PMSA_SHIFT;
        end
      end
      PMSA_SHIFT: begin
        if (rise_i) begin
          if (rd && cnt >= `PMSA_BIT_DATA) begin
            next_rdsh = {rdsh[14:0], mdio_i}; // see RULE3
          end
          if (cnt == `PMSA_BIT_LAST) begin
            next_state = PMSA_DONE;
          end else begin
            next_cnt = cnt + 6'h01;
          end
        end
        if (fall_i) begin
          next_out = shreg[63];
          next_shreg = {shreg[62:0], 1'b0};
          next_oe = !(rd && cnt >= `PMSA_BIT_RELEASE); // see RULE4
        end
      end
      PMSA_DONE: begin
        next_out = 1'b0;
        next_oe = 1'b0;
        next_done = 1'b1; // see RULE17
        next_state = PMSA_IDLE;
      end
      default: next_state = PMSA_IDLE;
    endcase
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= PMSA_IDLE;
      cnt <= 6'h00;
      shreg <= 64'h0;
      rdsh <= 16'h0;
      rd <= 1'b0;
      mdio_o <= 1'b0;
      mdio_oe_o <= 1'b0;
      done <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      shreg <= next_shreg;
      rdsh <= next_rdsh;
      rd <= next_rd;
      mdio_o <= next_out;
      mdio_oe_o <= next_oe;
      done <= next_done;
    end
  end
  assign rsp_o = '{done: done, rdata: rdsh};
  a_read_release: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see RULE4
    state == PMSA_SHIFT && rd && cnt > `PMSA_BIT_RELEASE |-> !mdio_oe_o)
    else $error("read frame still drives data line");
  a_done_after_last: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see RULE17
    state == PMSA_SHIFT && rise_i && cnt == `PMSA_BIT_LAST |=> ##1 done && state == PMSA_IDLE)
    else $error("transfer did not end after last bit");
endmodule : pmsa_mgmt_engine

//--- pmsa_top.sv
// Top of the transceiver management and status block: registers,
// status mirrors, management clock and frame engine.
// Assumes a one-cycle strobe register port on REF_CLK_I; transceiver
// status and the data line come from outside and are synchronised here.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps
`include "pmsa_defines.svh"
module pmsa_top import pmsa_pkg::*; (
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  // Register port
  input wire logic [7:0] ADDR_I,
  input wire logic [7:0] WR_DATA_I,
  input wire logic WR_STB_I,
  input wire logic RD_STB_I,
  output logic [7:0] RD_DATA_O,
  // Configured mode, same clock
  input wire logic [2:0] MODE_CTRL_I,
  // Transceiver state, asynchronous
  input wire pmsa_xstat_t XSTAT_I,
  // Management serial link
  output logic MDC_O,
  input wire logic MDIO_I,
  output logic MDIO_O,
  output logic MDIO_OE_O
);
  // Synchronisers
  logic [8:0] sync1;
  logic [8:0] sync2;
  pmsa_xstat_t xs;
  logic mdio_s;
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      sync1 <= {`PMSA_XSTAT_RESET, 1'b0};
      sync2 <= {`PMSA_XSTAT_RESET, 1'b0};
    end else begin
      sync1 <= {XSTAT_I, MDIO_I};
      sync2 <= sync1;
    end
  end
  assign xs = pmsa_xstat_t'(sync2[8:1]);
  assign mdio_s = sync2[0];

  // Status registers
  pmsa_stat0_t stat0, next_stat0;
  pmsa_stat1_t stat1, next_stat1;
  always_comb begin
    next_stat0.cable_absent = xs.cable_absent; // see RULE7
    next_stat0.rsvd = 1'b0;
    next_stat0.auto_off = MODE_CTRL_I[2]; // see RULE8
    next_stat0.configured_speed = MODE_CTRL_I[1]; // see RULE9
    next_stat0.configured_duplex = MODE_CTRL_I[0]; // see RULE10
    // Negotiated values mean nothing while the link is down
    next_stat0.negotiated_duplex = xs.link_up & xs.negotiated_duplex; // see RULE11
    next_stat0.negotiated_speed = xs.link_up & xs.negotiated_speed; // see RULE12
    next_stat0.link_up = xs.link_up; // see RULE7
    next_stat1.activity = xs.activity; // see RULE16
    next_stat1.rsvd = 4'h0; // see RULE13
    next_stat1.new_page_received = xs.new_page_received; // see RULE14
    next_stat1.low_power_idle_enable = xs.low_power_idle_enable; // see RULE13
    next_stat1.calibration_removed = xs.calibration_removed; // see RULE13
  end
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      stat0 <= pmsa_stat0_t'(`PMSA_STAT0_RESET);
      stat1 <= pmsa_stat1_t'(`PMSA_STAT1_RESET); // see RULE15
    end else begin
      stat0 <= next_stat0;
      stat1 <= next_stat1;
    end
  end

  // Control registers
  logic [4:0] index, next_index;
  logic [15:0] wdata, next_wdata;
  logic [15:0] rdata, next_rdata;
  logic [7:0] cmd, next_cmd;
  logic [7:0] div, next_div;
  logic [7:0] rd_byte, next_rd_byte;
  pmsa_req_t req;
  pmsa_rsp_t rsp;

  function automatic logic wr_hit(input logic [7:0] ofs);
    wr_hit = WR_STB_I && (ADDR_I == ofs);
  endfunction : wr_hit

  always_comb begin
    next_index = index;
    next_wdata = wdata;
    next_rdata = rdata;
    next_cmd = cmd;
    next_div = div;
    if (wr_hit(`PMSA_OFS_INDEX)) begin
      next_index = WR_DATA_I[4:0]; // see RULE1
    end
    if (wr_hit(`PMSA_OFS_WDATA_LO)) begin
      next_wdata[7:0] = WR_DATA_I; // see RULE2
    end
    if (wr_hit(`PMSA_OFS_WDATA_HI)) begin
      next_wdata[15:8] = WR_DATA_I; // see RULE2
    end
    if (wr_hit(`PMSA_OFS_DIV)) begin
      next_div = WR_DATA_I; // see RULE5
    end
    // Only the two access codes start anything, and only while idle
    if (wr_hit(`PMSA_OFS_CMD) && cmd == `PMSA_CMD_IDLE &&
        (WR_DATA_I == `PMSA_CMD_WRITE || WR_DATA_I == `PMSA_CMD_READ)) begin
      next_cmd = WR_DATA_I; // see RULE4
    end
    if (rsp.done) begin
      next_cmd = `PMSA_CMD_IDLE; // see RULE17
      if (cmd == `PMSA_CMD_READ) begin
        next_rdata = rsp.rdata; // see RULE3
      end
    end
  end
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      index <= 5'h00;
      wdata <= 16'h0000;
      rdata <= 16'h0000;
      cmd <= `PMSA_CMD_IDLE;
      div <= `PMSA_DIV_RESET;
    end else begin
      index <= next_index;
      wdata <= next_wdata;
      rdata <= next_rdata;
      cmd <= next_cmd;
      div <= next_div;
    end
  end

  // Read port: data stand only in the cycle after the strobe
  always_comb begin
    next_rd_byte = 8'h00;
    if (RD_STB_I) begin
      unique case (ADDR_I)
        `PMSA_OFS_STAT0: next_rd_byte = stat0;
        `PMSA_OFS_STAT1: next_rd_byte = stat1;
        `PMSA_OFS_INDEX: next_rd_byte = {3'h0, index}; // see RULE1
        `PMSA_OFS_WDATA_LO: next_rd_byte = wdata[7:0];
        `PMSA_OFS_WDATA_HI: next_rd_byte = wdata[15:8];
        `PMSA_OFS_RDATA_LO: next_rd_byte = rdata[7:0]; // see RULE3
        `PMSA_OFS_RDATA_HI: next_rd_byte = rdata[15:8]; // see RULE3
        `PMSA_OFS_CMD: next_rd_byte = cmd;
        `PMSA_OFS_DIV: next_rd_byte = div;
        default: next_rd_byte = 8'h00;
      endcase
    end
  end
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rd_byte <= 8'h00;
    end else begin
      rd_byte <= next_rd_byte;
    end
  end
  assign RD_DATA_O = rd_byte;

  // Management clock and frame engine
  logic rise;
  logic fall;
  assign req = '{start: cmd != `PMSA_CMD_IDLE, is_read: cmd == `PMSA_CMD_READ,
                 reg_index: index, wdata: wdata};

  pmsa_clk_div u_clk_div (
    .clk_i(REF_CLK_I),
    .rst_n_i(RESET_N_I),
    .div_code_i(div),
    .mdc_o(MDC_O),
    .rise_o(rise),
    .fall_o(fall)
  );

  pmsa_mgmt_engine u_engine (
    .clk_i(REF_CLK_I),
    .rst_n_i(RESET_N_I),
    .req_i(req),
    .rise_i(rise),
    .fall_i(fall),
    .mdio_i(mdio_s),
    .rsp_o(rsp),
    .mdio_o(MDIO_O),
    .mdio_oe_o(MDIO_OE_O)
  );

  // Checks
  sequence s_idle_cmd_write(logic [7:0] code);
    WR_STB_I && ADDR_I == `PMSA_OFS_CMD && WR_DATA_I == code && cmd == `PMSA_CMD_IDLE && !rsp.done;
  endsequence
  sequence s_read_of(logic [7:0] ofs);
    RD_STB_I && ADDR_I == ofs;
  endsequence

  a_index_reserved: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I) // see RULE1
    s_read_of(`PMSA_OFS_INDEX) |=> RD_DATA_O[7:5] == 3'h0)
    else $error("index reserved bits not zero");
  a_wdata_high: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I) // see RULE2
    WR_STB_I && ADDR_I == `PMSA_OFS_WDATA_HI
    |=> wdata[15:8] == $past(WR_DATA_I) && wdata[7:0] == $past(wdata[7:0]))
    else $error("write data byte order wrong");
  a_rdata_load: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I) // see RULE3
    rsp.done && cmd == `PMSA_CMD_READ |=> rdata == $past(rsp.rdata) && cmd == `PMSA_CMD_IDLE)
    else $error("read data not loaded at end of read");
  a_cmd_start: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I) // see RULE4
    s_idle_cmd_write(`PMSA_CMD_READ) |=> cmd == `PMSA_CMD_READ ##1 req.is_read)
    else $error("read command not taken");
  a_cmd_clear: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I) // see RULE17
    rsp.done |=> cmd == `PMSA_CMD_IDLE)
    else $error("command not cleared at end of transfer");
  a_mode_mirror: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I) // see RULE8
    1'b1 |=> {stat0.auto_off, stat0.configured_speed, stat0.configured_duplex} == $past(MODE_CTRL_I))
    else $error("configured mode bits do not follow mode control");
  a_link_gating: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I) // see RULE11
    !stat0.link_up |-> stat0.negotiated_duplex == 1'b0 && stat0.negotiated_speed == 1'b0)
    else $error("negotiated bits set with link down");
  a_stat1_reserved: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I) // see RULE13
    s_read_of(`PMSA_OFS_STAT1) |=> RD_DATA_O[6:3] == 4'h0 && RD_DATA_O == $past(stat1))
    else $error("status one read wrong");
  a_activity_follow: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I) // see RULE16
    $rose(XSTAT_I.activity) ##1 XSTAT_I.activity [*2] |=> stat1.activity)
    else $error("activity bit did not follow transceiver");
  a_read_strobe_only: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I) // see RULE3
    !RD_STB_I |=> RD_DATA_O == 8'h00)
    else $error("read data present without strobe");
endmodule : pmsa_top

//--- pmsa_xcvr_model.sv
// Behavioural model of the transceiver's internal management register set.
// Assumes it sees the resolved data line and the block's MDC and output enable.
`timescale 1ns/100ps
module pmsa_xcvr_model (
  // Clock and management link
  input wire logic clk_i,
  input wire logic mdc_i,
  input wire logic mdio_i,
  input wire logic mdio_oe_i,
  input wire logic slow_i,
  // Answer and observation
  output logic mdio_o,
  output logic [31:0] frames_o,
  output logic [20:0] last_wr_o
);
  logic [15:0] mem [32];
  logic [63:0] sh;
  logic [6:0] cnt;
  logic [1:0] op;
  logic [4:0] idx;
  logic in_frame;
  logic drv;
  logic bit_val;
  logic last;
  initial begin
    for (int i = 0; i < 32; i++) mem[i] = 16'hc3a0 + 16'(i);
    {sh, cnt, op, idx, in_frame, drv, bit_val, last} = '0;
    frames_o = '0;
    last_wr_o = '0;
  end
  // A released line shows the inverse of the last driven level
  always @(posedge clk_i) if (mdio_oe_i) last <= mdio_i;
  assign mdio_o = drv ? bit_val : ~last;
  always @(posedge mdc_i) begin
    if (in_frame || mdio_oe_i) begin
      in_frame = 1'b1;
      sh = {sh[62:0], mdio_i};
      cnt = cnt + 7'h01;
      if (cnt == 7'h24) op = sh[1:0];
      if (cnt == 7'h2e) idx = sh[4:0];
      if (cnt == 7'h40) begin
        if (op == 2'h1) begin
          mem[idx] = sh[15:0];
          last_wr_o = {idx, sh[15:0]};
        end
        frames_o = frames_o + 32'h1;
        in_frame = 1'b0;
        cnt = '0;
      end
    end
  end
  // Read answer: turnaround zero, then sixteen bits MSB first, prompt or late
  always @(negedge mdc_i) begin
    if (in_frame && op == 2'h2 && cnt >= 7'h2f) begin
      #(slow_i ? 40 : 1);
      bit_val = (cnt == 7'h2f) ? 1'b0 : mem[idx][4'(7'h3f - cnt)];
      drv = 1'b1;
    end else begin
      drv = 1'b0;
    end
  end
endmodule : pmsa_xcvr_model

//--- pmsa_top_tb.sv
// Self-checking bench for the management and status block.
// Assumes the design files and the transceiver model are compiled first.
`timescale 1ns/100ps
module pmsa_top_tb import pmsa_pkg::*;;
  localparam logic [7:0] RST_ADDR [11] = '{8'h3c, 8'h3d, 8'h3e, 8'h3f, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46};
  localparam logic [7:0] RST_VAL [11] = '{8'h00, 8'h81, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
  localparam logic [7:0] DIV_CODE [4] = '{8'h00, 8'h01, 8'hff, 8'h02};
  localparam int DIV_PER [4] = '{32, 64, 128, 128};
  localparam logic [7:0] BAD_CMD [3] = '{8'h00, 8'h03, 8'hff};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [2:0] mode = 3'h0;
  pmsa_xstat_t xstat = 8'h09;
  logic slow = 1'b0;
  logic [7:0] rdata;
  logic mdc;
  logic mdio_out;
  logic mdio_oe;
  logic mdio_xcvr;
  logic mdio_line;
  logic [31:0] frames;
  logic [20:0] last_wr;
  int error_cnt = 0;
  int num_checks = 0;
  int seed = 32'ha4b4;
  int cyc = 0;
  always #2 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  assign mdio_line = mdio_oe ? mdio_out : mdio_xcvr;
  pmsa_top DUT (.REF_CLK_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr), .WR_DATA_I(wdata), .WR_STB_I(wr),
    .RD_STB_I(rd), .RD_DATA_O(rdata), .MODE_CTRL_I(mode), .XSTAT_I(xstat), .MDC_O(mdc),
    .MDIO_I(mdio_line), .MDIO_O(mdio_out), .MDIO_OE_O(mdio_oe));
  pmsa_xcvr_model xcvr (.clk_i(clk), .mdc_i(mdc), .mdio_i(mdio_line), .mdio_oe_i(mdio_oe), .slow_i(slow),
    .mdio_o(mdio_xcvr), .frames_o(frames), .last_wr_o(last_wr));
  function automatic logic [7:0] exp_stat0(input pmsa_xstat_t x, input logic [2:0] m);
    return {x.cable_absent, 1'b0, m, x.link_up & x.negotiated_duplex, x.link_up & x.negotiated_speed, x.link_up};
  endfunction : exp_stat0
  function automatic logic [7:0] exp_stat1(input pmsa_xstat_t x);
    return {x.activity, 4'h0, x.new_page_received, x.low_power_idle_enable, x.calibration_removed};
  endfunction : exp_stat1
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk
  task automatic give_up(input string what);
    chk(32'h0, 32'h1, what);
    summarize();
  endtask : give_up
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string what);
    logic [7:0] d;
    rd_reg(a, d);
    chk(32'(d), 32'(e), what);
  endtask : rd_chk
  task automatic mdc_period(output int p);
    int rises;
    int t0;
    logic prv;
    rises = 0;
    t0 = 0;
    p = 0;
    prv = mdc;
    for (int n = 0; n < 1000 && rises < 3; n++) begin
      @(posedge clk);
      #1;
      if (mdc && !prv) begin
        rises++;
        if (rises == 2) t0 = cyc;
        if (rises == 3) p = cyc - t0;
      end
      prv = mdc;
    end
    if (rises < 3) give_up("management clock stopped");
  endtask : mdc_period
  // Starts one transfer, tries a second command while busy, waits for the self-clear
  task automatic xfer(input logic [7:0] cmd, input int per);
    logic [7:0] d;
    int t0;
    int el;
    logic [31:0] f0;
    f0 = frames;
    wr_reg(8'h44, cmd);
    t0 = cyc;
    rd_chk(8'h44, cmd, "command held while busy");
    wr_reg(8'h44, cmd ^ 8'h03);
    d = 8'hff;
    for (int n = 0; n < 6000 && d != 8'h00; n++) rd_reg(8'h44, d);
    if (d !== 8'h00) give_up("command never cleared");
    el = cyc - t0;
    chk(32'(el >= 63 * per && el <= 65 * per), 32'h1, "transfer length");
    chk(frames - f0, 32'h1, "one frame per command");
  endtask : xfer
  initial begin
    logic [31:0] r;
    logic [15:0] v;
    logic [4:0] ix;
    int p;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 11; i++) begin
      rd_chk(RST_ADDR[i], RST_VAL[i], "reset value");
      @(posedge clk);
      #1;
      chk(32'(rdata), 32'h0, "read data idles low");
    end
    for (int i = 0; i < 48; i++) begin
      r = $random(seed);
      @(posedge clk);
      xstat <= (i == 0) ? 8'hff : (i == 1) ? 8'h7e : r[7:0];
      mode <= r[10:8];
      repeat (4) @(posedge clk);
      rd_chk(8'h3c, exp_stat0(xstat, mode), "link status");
      rd_chk(8'h3d, exp_stat1(xstat), "activity status");
    end
    wr_reg(8'h3f, 8'hff);
    rd_chk(8'h3f, 8'h1f, "index width");
    for (int i = 0; i < 4; i++) begin
      wr_reg(8'h45, DIV_CODE[i]);
      rd_chk(8'h45, DIV_CODE[i], "divider readback");
      mdc_period(p);
      chk(32'(p), 32'(DIV_PER[i]), "management clock period");
    end
    // Divide by 128 keeps the management clock under its ceiling at this rate
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      ix = (i == 0) ? 5'h1f : r[20:16];
      v = (i == 0) ? 16'hffff : (i == 1) ? 16'h0001 : r[15:0];
      slow <= i[0];
      wr_reg(8'h3f, {3'h7, ix});
      wr_reg(8'h40, v[7:0]);
      wr_reg(8'h41, v[15:8]);
      rd_chk(8'h41, v[15:8], "write data high byte");
      xfer(8'h01, 128);
      chk(32'(last_wr), 32'({ix, v}), "transceiver got write");
      xfer(8'h02, 128);
      rd_chk(8'h42, v[7:0], "read data low byte");
      rd_chk(8'h43, v[15:8], "read data high byte");
    end
    for (int i = 0; i < 3; i++) begin
      wr_reg(8'h44, BAD_CMD[i]);
      rd_chk(8'h44, 8'h00, "unknown command ignored");
    end
    repeat (300) @(posedge clk);
    #1;
    chk(32'(mdio_oe), 32'h0, "no frame started");
    wr_reg(8'h3c, 8'ha5);
    wr_reg(8'h3d, 8'ha5);
    wr_reg(8'h42, 8'ha5);
    wr_reg(8'h43, 8'ha5);
    rd_chk(8'h42, v[7:0], "read-only low byte");
    rd_chk(8'h43, v[15:8], "read-only high byte");
    rd_chk(8'h3c, exp_stat0(xstat, mode), "read-only status");
    rd_chk(8'h3d, exp_stat1(xstat), "read-only activity");
    summarize();
  end
endmodule : pmsa_top_tb
